// ---- masr_pkg.sv ----
// Contract
// - Stack change control is eight bits, one per access level.
// - Call to more privileged level switches stack if any bit n..m set.
// - Module enable clear: level writes ignored, access status reads illegal code.
// - Module enable clear: every parameter validation command raises an exception.
// - Access level width code selects zero to three upper address bits.
// - Reset clears the access level width, disabling level checking.
// - Descriptor size code: 0 invalid, 1/2/3 need 16/32/64-byte alignment.
// - Fault status changes only on address test, register move or restore.
// - Bus error bit: search bus error, or cache hit with bus error flag.
// - Limit bit set on search limit violation, clear after cache-only test.
// - Supervisor bit: user code meets supervisor-only long descriptor during search.
// - Level violation bit: read level, or write level on a write test, exceeded during search only.
// - Write protected bit: write-protect flag seen or write level exceeded.
// - Invalid bit: invalid descriptor, bus error, limit, miss or erroneous hit.
// - Modified bit reflects modified flag of hit entry or page descriptor.
// - Gate bit reflects gate flag of hit entry or page descriptor.
// - Shared bit set when translation found with shared-global long descriptor.
// - Level number records tables used; zero after cache-only test.
// - Eight 16-bit breakpoint opcode registers supply the replacement opcode.
// - Eight 16-bit breakpoint control registers hold enable and repeat count.
// - Control enable bit enables the matching breakpoint instruction.
// - Zero skip count ends the breakpoint acknowledge with a bus error.
// - Registers are read and written by register move; moves have no side effects.
package masr_pkg;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned LVL_W  = 3;
   localparam int unsigned NUM_BP = 8;
   localparam int unsigned CNT_W  = 8;

   // Register select codes of the register move port.
   localparam logic [4:0] RS_STACK_CHG = 5'h00;
   localparam logic [4:0] RS_ACC_CTRL  = 5'h01;
   localparam logic [4:0] RS_FAULT_ST  = 5'h02;
   localparam logic [4:0] RS_BKPT_OP0  = 5'h08;
   localparam logic [4:0] RS_BKPT_CTL0 = 5'h10;
   localparam logic [1:0] RS_GRP_OP    = 2'h1;
   localparam logic [1:0] RS_GRP_CTL   = 2'h2;

   // Access control fields.
   localparam int unsigned AC_MOD_EN = 7;
   localparam int unsigned AC_ALW_LO = 4;
   localparam int unsigned AC_MDS_LO = 0;

   // Fault status fields.
   localparam int unsigned FS_BUS_ERROR_FLAG  = 15;
   localparam int unsigned FS_LIMIT = 14;
   localparam int unsigned FS_SUPV  = 13;
   localparam int unsigned FS_ALVL  = 12;
   localparam int unsigned FS_WPROT = 11;
   localparam int unsigned FS_INVAL = 10;
   localparam int unsigned FS_MOD   = 9;
   localparam int unsigned FS_GATE  = 7;
   localparam int unsigned FS_SHARE = 6;
   localparam int unsigned FS_NUM_LO = 0;
   localparam logic [15:0] FS_IMPL_MASK = 16'hFEC7;

   // Breakpoint control fields.
   localparam int unsigned BC_EN = 15;

   localparam logic [1:0] ALW_OFF  = 2'h0;
   localparam logic [1:0] MDS_NONE = 2'h0;
   localparam logic [15:0] RST_ZERO = 16'h0000;

   // Results of one address test as reported by the search engine.
   typedef struct packed {
      logic             cache_only;
      logic             is_write;
      logic             srch_bus_error_flag;
      logic             limit_hit;
      logic             user_fc;
      logic             supv_desc;
      logic             rd_exceed;
      logic             wr_exceed;
      logic             wp_seen;
      logic             inval_desc;
      logic             found;
      logic             hit;
      logic             hit_bus_error_flag;
      logic             mod_flag;
      logic             gate_flag;
      logic             shared_long;
      logic [LVL_W-1:0] tables;
   } masr_test_t;

   typedef struct packed {
      logic             en;
      logic [CNT_W-1:0] cnt;
   } masr_bctl_t;
endpackage

// ---- masr_regs.sv ----
`timescale 1ns/100ps
module masr_regs
   import masr_pkg::*;
(
   // Clock and reset.
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   // Register move and state restore port.
   input  wire logic              mv_req,
   input  wire logic              mv_wr,
   input  wire logic [4:0]        mv_sel,
   input  wire logic [DATA_W-1:0] mv_wdata,
   output logic                   mv_ack,
   output logic [DATA_W-1:0]      mv_rdata,
   // Address test results.
   input  wire logic              at_req,
   input  wire masr_test_t        at_res,
   // Module call and level registers.
   input  wire logic              call_req,
   input  wire logic [LVL_W-1:0]  call_cur,
   input  wire logic [LVL_W-1:0]  call_tgt,
   output logic                   stack_switch,
   input  wire logic              lvl_wr,
   input  wire logic [LVL_W-1:0]  lvl_wdata,
   output logic [LVL_W-1:0]       cur_level,
   input  wire logic [7:0]        as_code_in,
   output logic [7:0]             as_code_out,
   // Parameter validation.
   input  wire logic              pv_req,
   input  wire logic [LVL_W-1:0]  pv_operand,
   input  wire logic [LVL_W-1:0]  pv_caller,
   output logic                   pv_exc,
   // Module descriptor and level configuration.
   input  wire logic [5:0]        md_addr_lo,
   output logic                   md_valid,
   output logic [1:0]             level_bits,
   // Breakpoint acknowledge.
   input  wire logic              bk_req,
   input  wire logic [2:0]        bk_idx,
   output logic                   bk_done,
   output logic                   bk_bus_error_flag,
   output logic [DATA_W-1:0]      bk_opcode
);
   logic              rst_s1_ff;
   logic              rst_n_ff;
   logic [7:0]        stack_chg_ff;
   logic              mod_en_ff;
   logic [1:0]        alw_ff;
   logic [1:0]        mds_ff;
   logic [DATA_W-1:0] fault_ff;
   logic [DATA_W-1:0] nxt_fault;
   logic [DATA_W-1:0] bk_op_ff [NUM_BP];
   masr_bctl_t        bk_ctl_ff [NUM_BP];
   logic [LVL_W-1:0]  cur_level_ff;
   logic              mv_ack_ff;
   logic [DATA_W-1:0] mv_rdata_ff;
   logic              bk_done_ff;
   logic              bk_bus_error_flag_ff;
   logic [DATA_W-1:0] bk_opcode_ff;
   logic [7:0]        call_mask;
   logic [2:0]        lvl_mask;
   logic              wr_stb;
   masr_bctl_t        sel_ctl;

   // The release of rstn is retimed so that every register leaves reset
   // on the same edge; the cost is two cycles of extra reset latency.
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_s1_ff <= 1'b0;
         rst_n_ff  <= 1'b0;
      end
      else
      begin
         rst_s1_ff <= 1'b1;
         rst_n_ff  <= rst_s1_ff;
      end
   end

   assign wr_stb = mv_req && mv_wr;

   always_ff @(posedge ref_clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         stack_chg_ff <= RST_ZERO[7:0];
      else if (wr_stb && mv_sel == RS_STACK_CHG)
         stack_chg_ff <= mv_wdata[7:0];
   end

   always_ff @(posedge ref_clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         mod_en_ff <= 1'b0;
         alw_ff    <= ALW_OFF;
         mds_ff    <= MDS_NONE;
      end
      else if (wr_stb && mv_sel == RS_ACC_CTRL)
      begin
         mod_en_ff <= mv_wdata[AC_MOD_EN];
         alw_ff    <= mv_wdata[AC_ALW_LO +: 2];
         mds_ff    <= mv_wdata[AC_MDS_LO +: 2];
      end
   end

   // Bus error from search or from erroneous cache hit.
   always_comb
   begin
      nxt_fault = RST_ZERO;
      if (at_res.cache_only)
      begin
         nxt_fault[FS_BUS_ERROR_FLAG]  = at_res.hit && at_res.hit_bus_error_flag;
         // Cache-only miss or erroneous hit is invalid.
         nxt_fault[FS_INVAL] = !at_res.hit || at_res.hit_bus_error_flag;
         // Modified flag of the hit entry.
         nxt_fault[FS_MOD]   = at_res.hit && at_res.mod_flag;
         // Gate flag of the hit entry.
         nxt_fault[FS_GATE]  = at_res.hit && at_res.gate_flag;
      end
      else
      begin
         nxt_fault[FS_BUS_ERROR_FLAG]  = at_res.srch_bus_error_flag;
         // Limit violation only from a search.
         nxt_fault[FS_LIMIT] = at_res.limit_hit;
         nxt_fault[FS_SUPV]  = at_res.user_fc && at_res.supv_desc;
         // Read level, plus write level for write tests.
         nxt_fault[FS_ALVL]  = at_res.rd_exceed
                               || (at_res.is_write && at_res.wr_exceed);
         nxt_fault[FS_INVAL] = at_res.inval_desc || at_res.srch_bus_error_flag
                               || at_res.limit_hit;
         nxt_fault[FS_MOD]   = at_res.found && at_res.mod_flag;
         nxt_fault[FS_GATE]  = at_res.found && at_res.gate_flag;
         nxt_fault[FS_NUM_LO +: LVL_W] = at_res.tables;
      end
      // Write protection applies to every test kind.
      nxt_fault[FS_WPROT] = at_res.wp_seen || at_res.wr_exceed;
      // Shared-global long descriptor on a found translation.
      nxt_fault[FS_SHARE] = at_res.found && at_res.shared_long;
   end

   // Only a test or a move alters the fault status; a test wins.
   always_ff @(posedge ref_clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         fault_ff <= RST_ZERO;
      else if (at_req)
         fault_ff <= nxt_fault;
      else if (wr_stb && mv_sel == RS_FAULT_ST)
         fault_ff <= mv_wdata & FS_IMPL_MASK;
   end

   // Opcode and control banks, one entry per breakpoint.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_BP; gi++)
      begin : g_bp
         logic op_hit;
         logic ctl_hit;
         logic use_hit;
         assign op_hit  = wr_stb && mv_sel[4:3] == RS_GRP_OP
                          && mv_sel[2:0] == 3'(gi);
         assign ctl_hit = wr_stb && mv_sel[4:3] == RS_GRP_CTL
                          && mv_sel[2:0] == 3'(gi);
         assign use_hit = bk_req && bk_idx == 3'(gi)
                          && bk_ctl_ff[gi].en && bk_ctl_ff[gi].cnt != '0;
         always_ff @(posedge ref_clk or negedge rst_n_ff)
         begin
            if (!rst_n_ff)
               bk_op_ff[gi] <= RST_ZERO;
            else if (op_hit)
               bk_op_ff[gi] <= mv_wdata;
         end
         // Software write wins over the count going down.
         always_ff @(posedge ref_clk or negedge rst_n_ff)
         begin
            if (!rst_n_ff)
               bk_ctl_ff[gi] <= '0;
            else if (ctl_hit)
               bk_ctl_ff[gi] <= {mv_wdata[BC_EN], mv_wdata[CNT_W-1:0]};
            else if (use_hit)
               bk_ctl_ff[gi].cnt <= bk_ctl_ff[gi].cnt - 1'b1;
         end
      end
   endgenerate

   assign sel_ctl = bk_ctl_ff[bk_idx];

   // Zero count or disabled entry ends with bus error.
   always_ff @(posedge ref_clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         bk_done_ff   <= 1'b0;
         bk_bus_error_flag_ff   <= 1'b0;
         bk_opcode_ff <= RST_ZERO;
      end
      else
      begin
         bk_done_ff <= bk_req;
         if (bk_req)
         begin
            // Only an enabled entry returns its opcode.
            bk_bus_error_flag_ff   <= !sel_ctl.en || sel_ctl.cnt == '0;
            bk_opcode_ff <= (sel_ctl.en && sel_ctl.cnt != '0)
                            ? bk_op_ff[bk_idx] : RST_ZERO;
         end
      end
   end

   // Register move read path answers one cycle later.
   always_ff @(posedge ref_clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         mv_ack_ff   <= 1'b0;
         mv_rdata_ff <= RST_ZERO;
      end
      else
      begin
         mv_ack_ff <= mv_req;
         if (mv_req && !mv_wr)
         begin
            // Unmapped and unimplemented bits read zero.
            mv_rdata_ff <= RST_ZERO;
            if (mv_sel == RS_STACK_CHG)
               mv_rdata_ff[7:0] <= stack_chg_ff;
            else if (mv_sel == RS_ACC_CTRL)
            begin
               mv_rdata_ff[AC_MOD_EN]      <= mod_en_ff;
               mv_rdata_ff[AC_ALW_LO +: 2] <= alw_ff;
               mv_rdata_ff[AC_MDS_LO +: 2] <= mds_ff;
            end
            else if (mv_sel == RS_FAULT_ST)
               mv_rdata_ff <= fault_ff;
            else if (mv_sel[4:3] == RS_GRP_OP)
               mv_rdata_ff <= bk_op_ff[mv_sel[2:0]];
            else if (mv_sel[4:3] == RS_GRP_CTL)
            begin
               mv_rdata_ff[BC_EN]       <= bk_ctl_ff[mv_sel[2:0]].en;
               mv_rdata_ff[CNT_W-1:0]   <= bk_ctl_ff[mv_sel[2:0]].cnt;
            end
         end
      end
   end

   // Level writes take effect only with modules enabled.
   always_ff @(posedge ref_clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         cur_level_ff <= '0;
      else if (lvl_wr && mod_en_ff)
         cur_level_ff <= lvl_wdata;
   end

   // Disabled modules report the illegal access status code.
   assign as_code_out = mod_en_ff ? as_code_in : RST_ZERO[7:0];

   // Only the configured number of upper bits carry a level.
   always_comb
   begin
      unique case (alw_ff)
         2'h0: lvl_mask = 3'h0;
         2'h1: lvl_mask = 3'h1;
         2'h2: lvl_mask = 3'h3;
         2'h3: lvl_mask = 3'h7;
      endcase
   end
   assign level_bits = alw_ff;

   // Validation fails when disabled or operand is below the caller.
   assign pv_exc = pv_req && (!mod_en_ff
                   || (pv_operand & lvl_mask) < (pv_caller & lvl_mask));

   // Alignment demanded by the descriptor size code.
   always_comb
   begin
      unique case (mds_ff)
         2'h0: md_valid = 1'b0;
         2'h1: md_valid = md_addr_lo[3:0] == 4'h0;
         2'h2: md_valid = md_addr_lo[4:0] == 5'h00;
         2'h3: md_valid = md_addr_lo == 6'h00;
      endcase
   end

   // Levels m through n inclusive are examined.
   always_comb
   begin
      call_mask = 8'h00;
      for (int i = 0; i < 8; i++)
         call_mask[i] = i >= int'(call_tgt) && i <= int'(call_cur);
   end
   assign stack_switch = call_req && call_tgt < call_cur
                         && (stack_chg_ff & call_mask) != 8'h00;

   assign mv_ack    = mv_ack_ff;
   assign mv_rdata  = mv_rdata_ff;
   assign cur_level = cur_level_ff;
   assign bk_done   = bk_done_ff;
   assign bk_bus_error_flag   = bk_bus_error_flag_ff;
   assign bk_opcode = bk_opcode_ff;

   // The checks follow the retimed reset, so the two cycles in which the
   // registers still sit in reset raise no false alarm.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n_ff);

   fault_hold_a: assert property (
      !at_req && !(wr_stb && mv_sel == RS_FAULT_ST) |=> $stable(fault_ff))
      else $error("fault status changed without cause");
   cache_clear_a: assert property (
      at_req && at_res.cache_only |=> fault_ff[FS_LIMIT] == 1'b0
      && fault_ff[FS_SUPV] == 1'b0 && fault_ff[FS_ALVL] == 1'b0)
      else $error("search-only bits set after cache test");
   cache_num_a: assert property (
      at_req && at_res.cache_only |=> fault_ff[FS_NUM_LO +: LVL_W] == '0)
      else $error("level number nonzero after cache test");
   miss_inval_a: assert property (
      at_req && at_res.cache_only && !at_res.hit |=> fault_ff[FS_INVAL])
      else $error("cache miss not marked invalid");
   level_hold_a: assert property (
      !mod_en_ff |=> cur_level_ff == $past(cur_level_ff))
      else $error("level changed while modules disabled");
   pv_trap_a: assert property (
      pv_req && !mod_en_ff |-> pv_exc)
      else $error("validation passed while disabled");
   bk_zero_a: assert property (
      bk_req && sel_ctl.cnt == '0 |=> bk_done && bk_bus_error_flag)
      else $error("zero count did not end in bus error");
   mv_ack_a: assert property (
      mv_req |=> mv_ack ##1 (!mv_ack || $past(mv_req)))
      else $error("register move not answered next cycle");
   stack_sw_a: assert property (
      call_req && call_tgt < call_cur && stack_chg_ff[call_cur] |-> stack_switch)
      else $error("stack switch missed");
   md_zero_a: assert property (
      mds_ff == MDS_NONE |-> !md_valid)
      else $error("descriptor valid with size zero");
   stack_none_a: assert property (
      call_tgt >= call_cur |-> !stack_switch)
      else $error("stack switch on a call that gains no privilege");
   lvl_move_a: assert property (
      lvl_wr && mod_en_ff |=> cur_level_ff == $past(lvl_wdata))
      else $error("level write lost while modules enabled");
   as_code_a: assert property (
      !mod_en_ff |-> as_code_out == RST_ZERO[7:0])
      else $error("access status not illegal while disabled");
   fault_wr_a: assert property (
      wr_stb && mv_sel == RS_FAULT_ST && !at_req
      |=> fault_ff == ($past(mv_wdata) & FS_IMPL_MASK))
      else $error("fault status write lost");
   fault_pad_a: assert property (
      (fault_ff & ~FS_IMPL_MASK) == RST_ZERO)
      else $error("unimplemented fault status bit set");
   bk_op_a: assert property (
      bk_req && sel_ctl.en && sel_ctl.cnt != '0
      |=> bk_done && !bk_bus_error_flag && bk_opcode == $past(bk_op_ff[bk_idx]))
      else $error("breakpoint opcode not returned");

   bk_hit_c: cover property (bk_req && sel_ctl.en && sel_ctl.cnt != '0
      ##1 bk_done && !bk_bus_error_flag);
   cache_test_c: cover property (at_req && at_res.cache_only && at_res.hit);
   search_test_c: cover property (at_req && !at_res.cache_only
      && at_res.limit_hit);
   stack_sw_c: cover property (stack_switch);
   pv_exc_c: cover property (pv_req && mod_en_ff && pv_exc);
endmodule

// ---- masr_host.sv ----
`timescale 1ns/100ps
module masr_host
   import masr_pkg::*;
(
   // Clock.
   input  wire logic              ref_clk,
   // Register move port.
   output logic                   mv_req,
   output logic                   mv_wr,
   output logic [4:0]             mv_sel,
   output logic [DATA_W-1:0]      mv_wdata,
   input  wire logic              mv_ack,
   input  wire logic [DATA_W-1:0] mv_rdata
);
   initial
   begin
      mv_req   = 1'b0;
      mv_wr    = 1'b0;
      mv_sel   = 5'h1F;
      mv_wdata = 16'h0000;
   end

   // One register move.
   // Released qualifiers are inverted, so a design that samples them
   // outside a request sees garbage rather than a stale copy.
   task automatic move(input logic wr, input logic [4:0] sel,
                       input logic [DATA_W-1:0] wdata,
                       output logic [DATA_W-1:0] rdata,
                       output logic ack);
      @(negedge ref_clk);
      mv_req   = 1'b1;
      mv_wr    = wr;
      mv_sel   = sel;
      mv_wdata = wdata;
      @(negedge ref_clk);
      ack      = mv_ack;
      rdata    = mv_rdata;
      mv_req   = 1'b0;
      mv_wr    = ~wr;
      mv_sel   = ~sel;
      mv_wdata = ~wdata;
   endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/100ps
module tb
   import masr_pkg::*;
();
   localparam int CYC_LIMIT = 3000;
   logic              ref_clk     = 1'b0;
   logic              rstn        = 1'b0;
   logic              mv_req;
   logic              mv_wr;
   logic [4:0]        mv_sel;
   logic [DATA_W-1:0] mv_wdata;
   logic              mv_ack;
   logic [DATA_W-1:0] mv_rdata;
   logic              at_req      = 1'b0;
   masr_test_t        at_res      = '0;
   logic              call_req    = 1'b0;
   logic [LVL_W-1:0]  call_cur    = '0;
   logic [LVL_W-1:0]  call_tgt    = '0;
   logic              stack_switch;
   logic              lvl_wr      = 1'b0;
   logic [LVL_W-1:0]  lvl_wdata   = '0;
   logic [LVL_W-1:0]  cur_level;
   logic [7:0]        as_code_in  = 8'h5A;
   logic [7:0]        as_code_out;
   logic              pv_req      = 1'b0;
   logic [LVL_W-1:0]  pv_operand  = '0;
   logic [LVL_W-1:0]  pv_caller   = '0;
   logic              pv_exc;
   logic [5:0]        md_addr_lo  = '0;
   logic              md_valid;
   logic [1:0]        level_bits;
   logic              bk_req      = 1'b0;
   logic [2:0]        bk_idx      = '0;
   logic              bk_done;
   logic              bk_bus_error_flag;
   logic [DATA_W-1:0] bk_opcode;
   int                err_total   = 0;
   int                cmp_count   = 0;
   int                cyc         = 0;
   logic [15:0]       rd;
   logic              ack;
   logic [7:0]        scc_v;
   logic [7:0]        lvl_mask;

   masr_regs u_dut (.ref_clk(ref_clk), .rstn(rstn), .mv_req(mv_req),
      .mv_wr(mv_wr), .mv_sel(mv_sel), .mv_wdata(mv_wdata),
      .mv_ack(mv_ack), .mv_rdata(mv_rdata), .at_req(at_req),
      .at_res(at_res), .call_req(call_req), .call_cur(call_cur),
      .call_tgt(call_tgt), .stack_switch(stack_switch), .lvl_wr(lvl_wr),
      .lvl_wdata(lvl_wdata), .cur_level(cur_level),
      .as_code_in(as_code_in), .as_code_out(as_code_out),
      .pv_req(pv_req), .pv_operand(pv_operand), .pv_caller(pv_caller),
      .pv_exc(pv_exc), .md_addr_lo(md_addr_lo), .md_valid(md_valid),
      .level_bits(level_bits), .bk_req(bk_req), .bk_idx(bk_idx),
      .bk_done(bk_done), .bk_bus_error_flag(bk_bus_error_flag), .bk_opcode(bk_opcode));

   masr_host u_host (.ref_clk(ref_clk), .mv_req(mv_req), .mv_wr(mv_wr),
      .mv_sel(mv_sel), .mv_wdata(mv_wdata), .mv_ack(mv_ack),
      .mv_rdata(mv_rdata));

   always #5 ref_clk = ~ref_clk;

   task automatic complete_run();
      if (err_total == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == CYC_LIMIT)
      begin
         err_total++;
         complete_run();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [4:0] sel, input logic [15:0] d);
      u_host.move(1'b1, sel, d, rd, ack);
   endtask

   task automatic rdchk(input logic [4:0] sel, input logic [15:0] exp);
      u_host.move(1'b0, sel, 16'h0000, rd, ack);
      chk(ack, 16'h0001);
      chk(rd, exp);
   endtask

   task automatic at_test(input masr_test_t r, input logic [15:0] exp);
      @(negedge ref_clk);
      at_req = 1'b1;
      at_res = r;
      @(negedge ref_clk);
      at_req = 1'b0;
      at_res = ~r;
      rdchk(RS_FAULT_ST, exp);
   endtask

   task automatic bk(input logic [2:0] idx, input logic bus_error_flag,
                     input logic [15:0] op);
      @(negedge ref_clk);
      bk_req = 1'b1;
      bk_idx = idx;
      @(negedge ref_clk);
      bk_req = 1'b0;
      bk_idx = ~idx;
      chk(bk_done, 16'h0001);
      chk(bk_bus_error_flag, bus_error_flag);
      chk(bk_opcode, op);
   endtask

   task automatic lvl_write(input logic [LVL_W-1:0] v);
      @(negedge ref_clk);
      lvl_wr    = 1'b1;
      lvl_wdata = v;
      @(negedge ref_clk);
      lvl_wr    = 1'b0;
      lvl_wdata = ~v;
   endtask

   initial
   begin
      repeat (20) @(negedge ref_clk);
      rstn = 1'b1;
      repeat (5) @(negedge ref_clk);
      chk(level_bits, 16'h0000);
      rdchk(RS_ACC_CTRL, 16'h0000);
      rdchk(RS_FAULT_ST, 16'h0000);
      wr(RS_STACK_CHG, 16'hFFA5);
      rdchk(RS_STACK_CHG, 16'h00A5);
      wr(RS_ACC_CTRL, 16'hFFFF);
      rdchk(RS_ACC_CTRL, 16'h00B3);
      wr(RS_FAULT_ST, 16'hFFFF);
      rdchk(RS_FAULT_ST, FS_IMPL_MASK);
      wr(5'h03, 16'h1234);
      rdchk(5'h03, 16'h0000);
      for (int i = 0; i < NUM_BP; i++)
      begin
         wr(RS_BKPT_OP0 + 5'(i), 16'hA5C0 ^ 16'(i));
         wr(RS_BKPT_CTL0 + 5'(i), {i[0], 7'h7F, 8'(i)});
      end
      for (int i = 0; i < NUM_BP; i++)
      begin
         rdchk(RS_BKPT_OP0 + 5'(i), 16'hA5C0 ^ 16'(i));
         rdchk(RS_BKPT_CTL0 + 5'(i), {i[0], 7'h00, 8'(i)});
      end
      // Entry 2 is disabled but still holds a count.
      bk(3'h2, 1'b1, 16'h0000);
      wr(RS_BKPT_CTL0 + 5'h1, 16'h8002);
      bk(3'h1, 1'b0, 16'hA5C1);
      bk(3'h1, 1'b0, 16'hA5C1);
      bk(3'h1, 1'b1, 16'h0000);
      rdchk(RS_BKPT_CTL0 + 5'h1, 16'h8000);
      wr(RS_ACC_CTRL, 16'h0033);
      lvl_write(3'h5);
      chk(cur_level, 16'h0000);
      chk(as_code_out, 16'h0000);
      pv_req     = 1'b1;
      pv_operand = 3'h6;
      pv_caller  = 3'h1;
      #1 chk(pv_exc, 16'h0001);
      wr(RS_ACC_CTRL, 16'h00B3);
      lvl_write(3'h5);
      chk(cur_level, 16'h0005);
      chk(as_code_out, 16'h005A);
      chk(pv_exc, 16'h0000);
      pv_operand = 3'h1;
      pv_caller  = 3'h4;
      #1 chk(pv_exc, 16'h0001);
      @(negedge ref_clk);
      pv_req = 1'b0;
      for (int c = 0; c < 4; c++)
      begin
         wr(RS_ACC_CTRL, 16'h0080 | 16'(c << 4) | 16'(c));
         chk(level_bits, 16'(c));
         md_addr_lo = 6'h00;
         #1 chk(md_valid, 16'(c != 0));
         @(negedge ref_clk);
         md_addr_lo = 6'(4 << c);
         #1 chk(md_valid, 16'h0000);
         @(negedge ref_clk);
         md_addr_lo = 6'h30;
         #1 chk(md_valid, 16'(c == 1));
      end
      for (int k = 0; k < 2; k++)
      begin
         scc_v = (k == 0) ? 8'h10 : 8'h41;
         wr(RS_STACK_CHG, {8'h00, scc_v});
         call_req = 1'b1;
         for (int n = 1; n < 8; n++)
            for (int m = 0; m < n; m++)
            begin
               @(negedge ref_clk);
               call_cur = 3'(n);
               call_tgt = 3'(m);
               lvl_mask = (8'hFF << m) & (8'hFF >> (7 - n));
               #1 chk(stack_switch, 16'(|(scc_v & lvl_mask)));
            end
         @(negedge ref_clk);
         call_req = 1'b0;
      end
      rdchk(RS_FAULT_ST, FS_IMPL_MASK);
      at_test(masr_test_t'{srch_bus_error_flag: 1'b1, tables: 3'h3, default: '0},
              16'h8403);
      at_test(masr_test_t'{limit_hit: 1'b1, tables: 3'h2, default: '0},
              16'h4402);
      at_test(masr_test_t'{user_fc: 1'b1, supv_desc: 1'b1, tables: 3'h1,
              default: '0}, 16'h2001);
      at_test(masr_test_t'{supv_desc: 1'b1, tables: 3'h1, default: '0},
              16'h0001);
      at_test(masr_test_t'{rd_exceed: 1'b1, tables: 3'h4, default: '0},
              16'h1004);
      at_test(masr_test_t'{wr_exceed: 1'b1, tables: 3'h4, default: '0},
              16'h0804);
      at_test(masr_test_t'{is_write: 1'b1, wr_exceed: 1'b1, tables: 3'h4,
              default: '0}, 16'h1804);
      at_test(masr_test_t'{wp_seen: 1'b1, tables: 3'h2, default: '0},
              16'h0802);
      at_test(masr_test_t'{inval_desc: 1'b1, tables: 3'h5, default: '0},
              16'h0405);
      at_test(masr_test_t'{found: 1'b1, mod_flag: 1'b1, gate_flag: 1'b1,
              shared_long: 1'b1, tables: 3'h7, default: '0},
              16'h02C7);
      // A miss ignores the limit, supervisor and read-level faults and reports level zero.
      at_test(masr_test_t'{cache_only: 1'b1, limit_hit: 1'b1,
              user_fc: 1'b1, supv_desc: 1'b1, rd_exceed: 1'b1,
              tables: 3'h5, default: '0}, 16'h0400);
      at_test(masr_test_t'{cache_only: 1'b1, hit: 1'b1, found: 1'b1,
              hit_bus_error_flag: 1'b1, default: '0}, 16'h8400);
      at_test(masr_test_t'{cache_only: 1'b1, hit: 1'b1, found: 1'b1,
              mod_flag: 1'b1, gate_flag: 1'b1, wp_seen: 1'b1,
              tables: 3'h3, default: '0}, 16'h0A80);
      complete_run();
   end
endmodule
